// ===== logic/ebpwm_top.sv
// ebpwm_top: 10-bit enhanced pwm generator with axi4-lite registers
// Notes on behaviour
// - duty double-buffered in byte plus hidden latch
// - time base is counter plus two low bits
// - base equal to buffered duty clears output
// - resolution tops out at 10 bits
// - steps per period are four times limit+1
// - duty beyond period leaves output unchanged
// - sleep freezes everything, pins hold level
// - reset restores registers, releases all pins
// - timing derives from the system clock
// - arrangement field selects single, half, full bridge
// - low mode bits choose output polarity
// - enabling waits for a fresh period
// - zero control register releases the pins
// - half bridge: A waveform, B complement
// - half bridge rising edges delayed by dead band
// - forward: A active, D modulated, B C off
// - reverse: C active, B modulated, A D off
// - single mode pins enabled by steering only
// - unused pins released to other functions
// - period end clears counter, sets pin unless pending duty is zero, latches duty
// - pending duty from byte plus two control bits
// - buffer byte read-only while pwm active
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
module ebpwm_top #(
  parameter int unsigned NUM_TMR = 3
) (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  input  wire ebpwm_pkg::ebpwm_axi_req_s axi_i,
  output var  ebpwm_pkg::ebpwm_axi_rsp_s axi_o,
  output var  ebpwm_pkg::ebpwm_pins_s    pins_o,
  output var  logic [7:0]                alt_pin_sel
);
  import ebpwm_pkg::*;

  if (NUM_TMR < 1 || NUM_TMR > 4) begin : g_chk
    $error("NUM_TMR must lie in 1..4");
  end

  typedef struct packed {
    ebpwm_ctrl_s                    ctrl;
    logic [7:0]                     dpend;
    logic [7:0]                     dbuf;
    logic [1:0]                     dlat;
    logic [DB_W-1:0]                dband;
    logic [3:0]                     steer;
    logic [1:0]                     tsel;
    logic [7:0]                     apsel;
    logic [NUM_TMR-1:0][7:0]        lim;
    logic [NUM_TMR-1:0][7:0]        cnt;
    ebpwm_tctl_s [NUM_TMR-1:0]      ctl;
    logic [NUM_TMR-1:0][SUB_W-1:0]  sub;
    logic                           armed;
    logic                           pwm;
    logic [DBC_W-1:0]               dba;
    logic [DBC_W-1:0]               dbb;
    ebpwm_pins_s                    pins;
    logic                           aw_have;
    logic [ADDR_W-1:0]              aw_addr;
    logic                           w_have;
    logic [DATA_W-1:0]              wdata;
    logic [3:0]                     wstrb;
    logic                           awrdy;
    logic                           wrdy;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           arrdy;
    logic                           rvalid;
    logic [DATA_W-1:0]              rdata;
    logic [1:0]                     rresp;
  } ebpwm_state_s;

  ebpwm_state_s s_r;
  ebpwm_state_s s_nxt;

  logic [NUM_TMR-1:0] tinc;
  logic [NUM_TMR-1:0] wrap;

  // per-timer tick and period-end detection
  for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
    assign tinc[t] = s_r.ctl[t].on && (s_r.sub[t] == ebpwm_sub_top(s_r.ctl[t].presc));
    assign wrap[t] = tinc[t] && (s_r.cnt[t] == s_r.lim[t]);
  end

  logic [1:0]  sel;
  logic        pwm_en;
  logic        pstart;
  logic [9:0]  duty;
  logic [9:0]  pend;
  logic [9:0]  base_n;
  logic [DBC_W-1:0] db_tgt;
  logic [3:0]  act;
  logic [3:0]  used;
  logic [3:0]  inv;
  logic        da;
  logic        db;
  logic [7:0]  wb;
  logic        wr_go;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  rb;

  assign sel    = (32'(s_r.tsel) < NUM_TMR) ? s_r.tsel : 2'h0;
  assign pwm_en = (s_r.ctrl.mode[3:2] == MODE_PWM);
  assign pstart = wrap[sel];
  assign duty   = {s_r.dbuf, s_r.dlat};
  assign pend   = {s_r.dpend, s_r.ctrl.dlow};
  assign db_tgt = DBC_W'(s_r.dband * INSN_CLKS);
  assign wb     = s_r.wdata[7:0];
  assign wr_go  = s_r.aw_have && s_r.w_have && !s_r.bvalid;

  always_comb begin
    s_nxt  = s_r;
    base_n = '0;
    act    = '0;
    used   = '0;
    inv    = '0;
    da     = 1'b0;
    db     = 1'b0;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    rb     = '0;

    // timers advance every sys_clk, so output timing scales with it
    for (int t = 0; t < NUM_TMR; t++) begin
      if (s_r.ctl[t].on) begin
        s_nxt.sub[t] = tinc[t] ? '0 : s_r.sub[t] + 1'b1;
        if (wrap[t]) begin
          s_nxt.cnt[t] = '0;
        end else if (tinc[t]) begin
          s_nxt.cnt[t] = s_r.cnt[t] + 1'b1;
        end
      end
    end
    // base steps once per prescaled clock, 4*(limit+1) steps a period
    base_n = {s_nxt.cnt[sel], ebpwm_low2(s_r.ctl[sel].presc, s_nxt.sub[sel])};

    // waveform core
    if (!pwm_en) begin
      s_nxt.armed = 1'b0;
      s_nxt.pwm   = 1'b0;
    end else if (pstart) begin
      s_nxt.armed = 1'b1;
      s_nxt.dbuf  = s_r.dpend;
      s_nxt.dlat  = s_r.ctrl.dlow;
      s_nxt.pwm   = (pend != '0);
    end else if (s_r.armed && base_n == duty) begin
      // no match when duty exceeds the period, so the level holds
      s_nxt.pwm = 1'b0;
    end

    // dead band: count time since each leg wanted to turn on
    // counts saturate, so shrinking the delay mid-run cannot strand a leg
    if (!s_nxt.pwm) begin
      s_nxt.dba = '0;
    end else if (s_r.dba < db_tgt) begin
      s_nxt.dba = s_r.dba + 1'b1;
    end
    if (s_nxt.pwm || !s_nxt.armed) begin
      s_nxt.dbb = '0;
    end else if (s_r.dbb < db_tgt) begin
      s_nxt.dbb = s_r.dbb + 1'b1;
    end
    // registered count is time already waited: the leg waits the full delay
    // a leg whose on-time is shorter than the delay never turns on
    da = s_nxt.pwm && (s_r.dba >= db_tgt);
    db = !s_nxt.pwm && s_nxt.armed && (s_r.dbb >= db_tgt);

    // output arrangement, bit 0 is output A
    case (s_r.ctrl.arr)
      ARR_SINGLE: begin
        act  = {4{s_nxt.pwm}};
        used = s_r.steer;
      end
      ARR_HALF: begin
        act  = {2'b00, db, da};
        used = 4'b0011;
      end
      ARR_FWD: begin
        act  = {s_nxt.pwm, 1'b0, 1'b0, 1'b1};
        used = 4'b1111;
      end
      ARR_REV: begin
        act  = {1'b0, 1'b1, s_nxt.pwm, 1'b0};
        used = 4'b1111;
      end
      default: begin
        act  = '0;
        used = '0;
      end
    endcase
    if (!s_nxt.armed) begin
      act = '0;
    end
    inv = {s_r.ctrl.mode[0], s_r.ctrl.mode[1], s_r.ctrl.mode[0], s_r.ctrl.mode[1]};
    if (pwm_en) begin
      // port direction outside still gates the real driver
      s_nxt.pins.oe_n = ~used;
      s_nxt.pins.out  = (act ^ inv) & used;
    end else begin
      s_nxt.pins.oe_n = 4'hF;
      s_nxt.pins.out  = '0;
    end

    // axi write channels, address and data in either order
    if (axi_i.awvalid && s_r.awrdy) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = axi_i.awaddr;
    end
    if (axi_i.wvalid && s_r.wrdy) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata  = axi_i.wdata;
      s_nxt.wstrb  = axi_i.wstrb;
    end
    if (s_r.bvalid && axi_i.bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      // software write lands after the hardware update and wins
      case (s_r.aw_addr)
        OFS_CTRL: begin
          wr_hit = 1'b1;
          if (s_r.wstrb[0]) begin
            s_nxt.ctrl = ebpwm_ctrl_s'(wb);
          end
        end
        OFS_DPEND: begin
          wr_hit = 1'b1;
          if (s_r.wstrb[0]) begin
            s_nxt.dpend = wb;
          end
        end
        OFS_DBUF: begin
          wr_hit = 1'b1;
          if (s_r.wstrb[0] && !pwm_en) begin
            s_nxt.dbuf = wb;
          end
        end
        OFS_DBAND: begin
          wr_hit = 1'b1;
          if (s_r.wstrb[0]) begin
            s_nxt.dband = wb[DB_W-1:0];
          end
        end
        OFS_STEER: begin
          wr_hit = 1'b1;
          if (s_r.wstrb[0]) begin
            s_nxt.steer = wb[3:0];
          end
        end
        OFS_TSEL: begin
          wr_hit = 1'b1;
          if (s_r.wstrb[0]) begin
            s_nxt.tsel = wb[1:0];
          end
        end
        OFS_APSEL: begin
          wr_hit = 1'b1;
          if (s_r.wstrb[0]) begin
            s_nxt.apsel = wb;
          end
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
      for (int t = 0; t < NUM_TMR; t++) begin
        if (s_r.aw_addr == ADDR_W'(OFS_TMR + t * TMR_STEP + OFS_LIM)) begin
          wr_hit = 1'b1;
          if (s_r.wstrb[0]) begin
            s_nxt.lim[t] = wb;
          end
        end
        if (s_r.aw_addr == ADDR_W'(OFS_TMR + t * TMR_STEP + OFS_TCTL)) begin
          wr_hit = 1'b1;
          if (s_r.wstrb[0]) begin
            s_nxt.ctl[t].on    = wb[2];
            s_nxt.ctl[t].presc = wb[1:0];
          end
        end
        if (s_r.aw_addr == ADDR_W'(OFS_TMR + t * TMR_STEP + OFS_CNT)) begin
          wr_hit = 1'b1;
          if (s_r.wstrb[0]) begin
            s_nxt.cnt[t] = wb;
            s_nxt.sub[t] = '0;
          end
        end
      end
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    s_nxt.awrdy = !s_nxt.aw_have;
    s_nxt.wrdy  = !s_nxt.w_have;

    // axi read channel
    if (s_r.rvalid && axi_i.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (axi_i.arvalid && s_r.arrdy) begin
      case (axi_i.araddr)
        OFS_CTRL: begin
          rd_hit = 1'b1;
          rb     = s_r.ctrl;
        end
        OFS_DPEND: begin
          rd_hit = 1'b1;
          rb     = s_r.dpend;
        end
        OFS_DBUF: begin
          rd_hit = 1'b1;
          rb     = s_r.dbuf;
        end
        OFS_DBAND: begin
          rd_hit = 1'b1;
          rb     = 8'(s_r.dband);
        end
        OFS_STEER: begin
          rd_hit = 1'b1;
          rb     = 8'(s_r.steer);
        end
        OFS_TSEL: begin
          rd_hit = 1'b1;
          rb     = 8'(s_r.tsel);
        end
        OFS_APSEL: begin
          rd_hit = 1'b1;
          rb     = s_r.apsel;
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
      for (int t = 0; t < NUM_TMR; t++) begin
        if (axi_i.araddr == ADDR_W'(OFS_TMR + t * TMR_STEP + OFS_LIM)) begin
          rd_hit = 1'b1;
          rb     = s_r.lim[t];
        end
        if (axi_i.araddr == ADDR_W'(OFS_TMR + t * TMR_STEP + OFS_TCTL)) begin
          rd_hit = 1'b1;
          rb     = s_r.ctl[t];
        end
        if (axi_i.araddr == ADDR_W'(OFS_TMR + t * TMR_STEP + OFS_CNT)) begin
          rd_hit = 1'b1;
          rb     = s_r.cnt[t];
        end
      end
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = DATA_W'(rb);
      s_nxt.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    s_nxt.arrdy = !s_nxt.rvalid;
  end

  // ce low is sleep: nothing moves, pins keep their level
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_r      <= '0;
      s_r.lim  <= {NUM_TMR{LIM_RST}};
      s_r.pins <= '{out: 4'h0, oe_n: 4'hF};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign axi_o = '{awready: s_r.awrdy, wready: s_r.wrdy, bvalid: s_r.bvalid, bresp: s_r.bresp,
                   arready: s_r.arrdy, rvalid: s_r.rvalid, rdata: s_r.rdata, rresp: s_r.rresp};
  assign pins_o      = s_r.pins;
  assign alt_pin_sel = s_r.apsel;
endmodule : ebpwm_top
`default_nettype wire

// ===== include/ebpwm_pkg.sv
// ebpwm_pkg: register map, field layouts, carriers and helpers of the bridge pwm generator
`default_nettype none
package ebpwm_pkg;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_DPEND   = 8'h04;
  localparam logic [7:0]  OFS_DBUF    = 8'h08;
  localparam logic [7:0]  OFS_DBAND   = 8'h0C;
  localparam logic [7:0]  OFS_STEER   = 8'h10;
  localparam logic [7:0]  OFS_TSEL    = 8'h14;
  localparam logic [7:0]  OFS_APSEL   = 8'h18;
  localparam logic [7:0]  OFS_TMR     = 8'h20;
  localparam logic [7:0]  TMR_STEP    = 8'h10;
  localparam logic [7:0]  OFS_LIM     = 8'h00;
  localparam logic [7:0]  OFS_TCTL    = 8'h04;
  localparam logic [7:0]  OFS_CNT     = 8'h08;
  localparam logic [7:0]  LIM_RST     = 8'hFF;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  MODE_PWM    = 2'h3;
  localparam int unsigned INSN_CLKS   = 4;
  localparam int unsigned DB_W        = 7;
  localparam int unsigned DBC_W       = 9;
  localparam int unsigned SUB_W       = 6;
  localparam logic [1:0]  PSC_1       = 2'h0;
  localparam logic [1:0]  PSC_4       = 2'h1;
  localparam logic [5:0]  SUB_TOP_1   = 6'h03;
  localparam logic [5:0]  SUB_TOP_4   = 6'h0F;
  localparam logic [5:0]  SUB_TOP_16  = 6'h3F;

  typedef enum logic [1:0] {
    ARR_SINGLE = 2'b00,
    ARR_FWD    = 2'b01,
    ARR_HALF   = 2'b10,
    ARR_REV    = 2'b11
  } ebpwm_arr_e;

  typedef struct packed {
    ebpwm_arr_e arr;
    logic [1:0] dlow;
    logic [3:0] mode;
  } ebpwm_ctrl_s;

  typedef struct packed {
    logic [4:0] rsv;
    logic       on;
    logic [1:0] presc;
  } ebpwm_tctl_s;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } ebpwm_axi_req_s;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } ebpwm_axi_rsp_s;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe_n;
  } ebpwm_pins_s;

  function automatic logic [SUB_W-1:0] ebpwm_sub_top(input logic [1:0] presc);
    case (presc)
      PSC_1:   return SUB_TOP_1;
      PSC_4:   return SUB_TOP_4;
      default: return SUB_TOP_16;
    endcase
  endfunction : ebpwm_sub_top

  // two low bits of the time base: clock phase at 1:1, else prescaler bits
  function automatic logic [1:0] ebpwm_low2(input logic [1:0] presc, input logic [SUB_W-1:0] sub);
    case (presc)
      PSC_1:   return sub[1:0];
      PSC_4:   return sub[3:2];
      default: return sub[5:4];
    endcase
  endfunction : ebpwm_low2
endpackage : ebpwm_pkg
`default_nettype wire

// ===== verification/ebpwm_checker.sv
// ebpwm_checker: concurrent checks on the pin and bus ports of the pwm generator
`default_nettype none
module ebpwm_checker #(
  parameter int unsigned NUM_TMR = 3
) (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  input  wire ebpwm_pkg::ebpwm_axi_req_s axi_i,
  input  wire ebpwm_pkg::ebpwm_axi_rsp_s axi_o,
  input  wire ebpwm_pkg::ebpwm_pins_s    pins_o,
  input  wire logic [7:0]                alt_pin_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  import ebpwm_pkg::*;
  logic [7:0] ctrl_r;
  logic [3:0] steer_r;
  logic [2:0] quiet_r;
  logic       wr;
  logic       settled;
  logic       pwm;

  // mirror of control writes; pins judged only once the write has had time to land
  assign wr = ce && axi_i.awvalid && axi_o.awready && axi_i.wvalid && axi_o.wready && axi_i.wstrb[0];
  assign settled = quiet_r == 3'h7;
  assign pwm = ctrl_r[3:2] == 2'b11;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r  <= 8'h00;
      steer_r <= 4'h0;
      quiet_r <= 3'h0;
    end else if (wr) begin
      if (axi_i.awaddr == OFS_CTRL) ctrl_r <= axi_i.wdata[7:0];
      if (axi_i.awaddr == OFS_STEER) steer_r <= axi_i.wdata[3:0];
      quiet_r <= 3'h0;
    end else if (ce && !settled) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  a_reset_state: assert property ($fell(srst) |-> pins_o.oe_n == 4'hF && pins_o.out == 4'h0 && alt_pin_sel == 8'h00)
    else $error("pins or alternate select not at reset values");
  a_sleep_hold: assert property (!ce |=> $stable(pins_o) && $stable(axi_o))
    else $error("outputs moved while clock enable low");
  a_released_low: assert property ((pins_o.out & pins_o.oe_n) == 4'h0)
    else $error("released pin shows a high level");
  a_off_release: assert property (settled && !pwm |-> pins_o.oe_n == 4'hF)
    else $error("pins still owned with pwm mode off");
  a_half_pins: assert property (settled && pwm && ctrl_r[7:6] == ARR_HALF |-> pins_o.oe_n == 4'b1100)
    else $error("half bridge pin ownership wrong");
  a_fwd_pins: assert property (settled && pwm && ctrl_r[7:6] == ARR_FWD |->
    pins_o.oe_n == 4'h0 && pins_o.out[1] == ctrl_r[0] && pins_o.out[2] == ctrl_r[1])
    else $error("forward bridge outputs b or c not inactive");
  a_rev_pins: assert property (settled && pwm && ctrl_r[7:6] == ARR_REV |->
    pins_o.oe_n == 4'h0 && pins_o.out[0] == ctrl_r[1] && pins_o.out[3] == ctrl_r[0])
    else $error("reverse bridge outputs a or d not inactive");
  a_steer_pins: assert property (settled && pwm && ctrl_r[7:6] == ARR_SINGLE |-> pins_o.oe_n == ~steer_r)
    else $error("single mode ownership differs from steering");
  a_read_answer: assert property (ce && axi_i.arvalid && axi_o.arready |=> axi_o.rvalid)
    else $error("read answer missing one cycle after address");
endmodule : ebpwm_checker
`default_nettype wire

// ===== verification/ebpwm_bridge_model.sv
// ebpwm_bridge_model: bridge driver stand-in that measures what reaches the wires
`default_nettype none
module ebpwm_bridge_model (
  input  wire logic                   sys_clk,
  input  wire ebpwm_pkg::ebpwm_pins_s pins,
  input  wire logic [3:0]             port_direction,
  output logic                        wa,
  output logic                        wb,
  output logic                        shoot,
  output logic [31:0]                 hi_a,
  output logic [31:0]                 hi_b,
  output logic [31:0]                 per_a
);
  timeunit 1ns;
  timeprecision 1ps;
  import ebpwm_pkg::*;
  logic [3:0]  lvl;
  logic        wa_d;
  logic [31:0] acc_a;
  logic [31:0] acc_b;
  logic [31:0] cnt;

  // undriven wires fall to the driver board pull-downs
  assign lvl = pins.out & ~pins.oe_n & ~port_direction;
  assign wa = lvl[0];
  assign wb = lvl[1];

  initial begin
    {shoot, wa_d, acc_a, acc_b, cnt, hi_a, hi_b, per_a} = '0;
  end

  // period and high times are taken between rises of wire a
  always @(posedge sys_clk) begin
    if (wa && wb) shoot <= 1'b1;
    wa_d <= wa;
    if (wa && !wa_d) begin
      {per_a, hi_a, hi_b} <= {cnt, acc_a, acc_b};
      {cnt, acc_a, acc_b} <= {32'h1, 32'h1, 31'h0, wb};
    end else begin
      cnt <= cnt + 1;
      acc_a <= acc_a + wa;
      acc_b <= acc_b + wb;
    end
  end
endmodule : ebpwm_bridge_model
`default_nettype wire

// ===== verification/tb.sv
// tb: self-checking bench of the bridge pwm generator
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ebpwm_pkg::*;
  logic           sys_clk, srst, ce, wa, wb, shoot;
  ebpwm_axi_req_s axi_i;
  ebpwm_axi_rsp_s axi_o;
  ebpwm_pins_s    pins_o, snap;
  logic [7:0]     alt_pin_sel, v;
  logic [3:0]     port_direction;
  logic [31:0]    hi_a, hi_b, per_a, rd;
  logic [1:0]     rr;
  int             err_count, checks, cyc, lim, psc, duty, per, db, n;

  ebpwm_top ebpwm_top_i (.sys_clk(sys_clk), .srst(srst), .ce(ce), .axi_i(axi_i), .axi_o(axi_o),
    .pins_o(pins_o), .alt_pin_sel(alt_pin_sel));
  ebpwm_bridge_model ebpwm_bridge_model_i (.sys_clk(sys_clk), .pins(pins_o), .port_direction(port_direction),
    .wa(wa), .wb(wb), .shoot(shoot), .hi_a(hi_a), .hi_b(hi_b), .per_a(per_a));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task close_out;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [7:0] ta(input int t, input logic [7:0] off);
    return OFS_TMR + TMR_STEP * t[7:0] + off;
  endfunction : ta

  // address and data offered together, each dropped once taken
  task axw(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    @(posedge sys_clk);
    axi_i.awvalid <= 1'b1;
    axi_i.awaddr <= a;
    axi_i.wvalid <= 1'b1;
    axi_i.wdata <= {24'h0000_00, d};
    axi_i.wstrb <= 4'hF;
    axi_i.bready <= 1'b1;
    {aw, w} = 2'b11;
    while (aw || w) begin
      @(posedge sys_clk);
      if (aw && axi_o.awready === 1'b1) begin
        aw = 1'b0;
        axi_i.awvalid <= 1'b0;
      end
      if (w && axi_o.wready === 1'b1) begin
        w = 1'b0;
        axi_i.wvalid <= 1'b0;
      end
    end
    while (axi_o.bvalid !== 1'b1) @(posedge sys_clk);
    rr = axi_o.bresp;
    axi_i.bready <= 1'b0;
  endtask : axw

  task axr(input logic [7:0] a);
    @(posedge sys_clk);
    axi_i.arvalid <= 1'b1;
    axi_i.araddr <= a;
    axi_i.rready <= 1'b1;
    do @(posedge sys_clk); while (axi_o.arready !== 1'b1);
    axi_i.arvalid <= 1'b0;
    do @(posedge sys_clk); while (axi_o.rvalid !== 1'b1);
    {rd, rr} = {axi_o.rdata, axi_o.rresp};
    axi_i.rready <= 1'b0;
  endtask : axr

  // counter restart keeps a shortened limit from running the long way round
  task cfg(input int t, input logic [7:0] c);
    axw(OFS_TSEL, t[7:0]);
    axw(ta(t, OFS_LIM), lim[7:0]);
    axw(ta(t, OFS_TCTL), {5'h00, 1'b1, t[1:0]});
    axw(OFS_DPEND, duty[9:2]);
    axw(OFS_CTRL, {c[7:6], duty[1:0], c[3:0]});
    axw(ta(t, OFS_CNT), 8'h00);
    per = 4 * (lim + 1) * psc;
    repeat (3 * per + 20) @(posedge sys_clk);
  endtask : cfg

  task count_hi;
    n = 0;
    repeat (per) begin
      @(posedge sys_clk);
      n += wa;
    end
  endtask : count_hi

  initial begin
    {ce, srst, port_direction} = 6'h3F;
    axi_i = '0;
    {err_count, checks, cyc} = '0;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    n = $urandom(12);
    axr(OFS_CTRL);
    chk(rd, 32'h0000_0000);
    axr(ta(0, OFS_LIM));
    chk(rd, {24'h0000_00, LIM_RST});
    axr(8'h1C);
    chk(rr, RESP_SLVERR);
    port_direction <= 4'h0;
    axw(OFS_STEER, 8'h01);
    for (int t = 0; t < 3; t++) begin
      psc = 1 << (2 * t);
      lim = 7 + $urandom % 8;
      duty = 13 + $urandom % (4 * lim - 22);
      cfg(t, {ARR_SINGLE, 2'b00, 4'hC});
      chk(per_a, per);
      chk(hi_a, duty * psc);
      axr(OFS_DBUF);
      chk(rd, duty >> 2);
      axw(OFS_DBUF, ~duty[9:2]);
      axr(OFS_DBUF);
      chk(rd, duty >> 2);
    end
    db = 1 + $urandom % 3;
    axw(OFS_DBAND, db[7:0]);
    cfg(2, {ARR_HALF, 2'b00, 4'hC});
    chk(hi_a, duty * psc - 4 * db);
    chk(hi_b, per - duty * psc - 4 * db);
    chk(shoot, 0);
    duty = 1020;
    cfg(2, {ARR_SINGLE, 2'b00, 4'hC});
    count_hi();
    chk(n, per);
    duty = 0;
    cfg(2, {ARR_SINGLE, 2'b00, 4'hC});
    count_hi();
    chk(n, 0);
    duty = 40;
    cfg(2, {ARR_FWD, 2'b00, 4'hC});
    chk(pins_o, 8'h90);
    cfg(2, {ARR_REV, 2'b00, 4'hF});
    chk(pins_o.out[2], 1'b0);
    ce <= 1'b0;
    @(posedge sys_clk);
    snap = pins_o;
    repeat (40) @(posedge sys_clk);
    chk(pins_o, snap);
    ce <= 1'b1;
    axw(OFS_CTRL, 8'h00);
    repeat (6) @(posedge sys_clk);
    chk(pins_o.oe_n, 4'hF);
    v = $urandom;
    axw(OFS_APSEL, v);
    repeat (2) @(posedge sys_clk);
    chk(alt_pin_sel, v);
    axw(8'h1C, 8'h5A);
    chk(rr, RESP_SLVERR);
    close_out();
  end
endmodule : tb

bind ebpwm_top ebpwm_checker #(.NUM_TMR(NUM_TMR)) ebpwm_checker_i (.sys_clk(sys_clk), .srst(srst), .ce(ce),
  .axi_i(axi_i), .axi_o(axi_o), .pins_o(pins_o), .alt_pin_sel(alt_pin_sel));
`default_nettype wire
